// *** src/tmb_pkg.sv ***
package tmb_pkg;
	// word indices; byte address on apb is four times the index
	localparam logic [13:0] IDX_ERROR_CODE = 14'h0000;
	localparam logic [13:0] IDX_CH3_SCALING_ENABLE = 14'h02f5;
	localparam logic [13:0] IDX_CH3_SCALING_LOWER_LIMIT = 14'h02f6;
	localparam logic [13:0] IDX_CH3_SCALING_UPPER_LIMIT = 14'h02f7;
	localparam logic [13:0] IDX_CH3_SCALED_VALUE = 14'h02f8;
	localparam logic [13:0] IDX_CH4_SCALING_ENABLE = 14'h0305;
	localparam logic [13:0] IDX_CH4_SCALING_LOWER_LIMIT = 14'h0306;
	localparam logic [13:0] IDX_CH4_SCALING_UPPER_LIMIT = 14'h0307;
	localparam logic [13:0] IDX_CH4_SCALED_VALUE = 14'h0308;
	localparam logic [13:0] IDX_SENSOR_COMPENSATION_SELECT = 14'h0311;
	localparam logic [13:0] IDX_CONVERSION_DONE_FLAGS = 14'h0312;
	localparam logic [13:0] IDX_EXTENSION_BITS_MONITOR = 14'h0313;
	localparam logic [13:0] IDX_SAMPLE_PERIOD_MONITOR = 14'h0314;
	// value after reset of every area
	localparam logic [15:0] RST_WORD = 16'h0000;
	// error code reported for a restricted write in operation mode (arbitrary value)
	localparam logic [15:0] ERR_WRITE_DATA = 16'h0bad;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	// backup-capable words, streamed out one per cycle
	localparam logic [2:0] BACKUP_FIRST = 3'h0;
	localparam logic [2:0] BACKUP_LAST = 3'h6;
	// automatic-setting flags per area kind; none of these areas is flagged
	localparam logic AUTO_SCALING = 1'b0;
	localparam logic AUTO_SENSOR = 1'b0;
	// width of the pin synchroniser chain
	localparam int SYNC_STAGES = 3;
	typedef enum logic [0:0] {
		BK_IDLE = 1'b0,
		BK_COPY = 1'b1
	} tmb_backup_state_t;
endpackage

// *** src/tmb_pin_sync.sv ***
`timescale 1ns/10ps
// three-stage synchroniser; output follows once stages two and three agree
module tmb_pin_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);
	logic [WIDTH-1:0] meta_q; // first stage, read only by second
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;

	// shift chain
	always_ff @(posedge clock) begin
		if (srst) begin
			meta_q <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
		end else begin
			meta_q <= pinIn;
			stage2_q <= meta_q;
			stage3_q <= stage2_q;
		end
	end

	// accept a bit only when the last two stages agree
	always_ff @(posedge clock) begin
		if (srst) begin
			pinOut <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_q[i] == stage3_q[i]) begin
					pinOut[i] <= stage3_q[i];
				end
			end
		end
	end
endmodule

// *** src/tmb_buffer_map.sv ***
`timescale 1ns/10ps
module tmb_buffer_map (
	input wire logic clock,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic backup_request_output,
	input wire logic apply_settings_output,
	input wire logic mode_select_output,
	input wire logic rangeChanged,
	input wire logic autoChangeEnable,
	input wire logic [15:0] process_value_ch3,
	input wire logic [15:0] process_value_ch4,
	input wire logic [15:0] conversionDoneIn,
	input wire logic [15:0] extensionBitsIn,
	input wire logic [15:0] samplePeriodIn,
	output logic nvWrValid,
	output logic [2:0] nvWrIndex,
	output logic [15:0] nvWrData,
	output logic backupBusy,
	output logic settingMode
);
	logic [2:0] pinSync; // synchronised host pins
	logic backupPin, applyPin, modePin;
	logic backupPin_q, applyPin_q; // previous samples for edges
	logic applySeenOn_q; // off then on seen in setting mode
	logic applyNow; // completion of off-on-off
	logic [1:0][15:0] enStage_q, loStage_q, upStage_q; // host-written values
	logic [1:0][15:0] enAct_q, loAct_q, upAct_q; // applied values
	logic [1:0][15:0] scaled_q; // scaled process value per channel
	logic [15:0] sensStage_q, sensAct_q;
	logic [15:0] errorCode_q;
	logic [15:0] doneFlags_q, extBits_q, samplePeriod_q;
	logic [15:0] rdWord; // decoded read data
	logic rdOnly, rdRestricted; // class of the addressed area
	logic rdMapped; // address names a listed area, not a system hole
	logic accessPhase, commitEdge, wrCommit, wrLegal;
	logic [13:0] wordIdx;
	tmb_pkg::tmb_backup_state_t bkState_q;
	logic [15:0] bkWord;
	logic [2:0] bkSel; // index of the word loaded next; while nvWrValid, data and nvWrIndex name the same word

	tmb_pin_sync #(
		.WIDTH(3)
	) uPinSync (
		.clock(clock),
		.srst(srst),
		.pinIn({mode_select_output, apply_settings_output, backup_request_output}),
		.pinOut(pinSync)
	);
	assign backupPin = pinSync[0];
	assign applyPin = pinSync[1];
	assign modePin = pinSync[2]; // high means operation mode

	// edge history of the synchronised pins
	always_ff @(posedge clock) begin
		if (srst) begin
			backupPin_q <= 1'b0;
			applyPin_q <= 1'b0;
		end else begin
			backupPin_q <= backupPin;
			applyPin_q <= applyPin;
		end
	end

	// off-on-off detector; leaving setting mode mid-pulse cancels it
	always_ff @(posedge clock) begin
		if (srst) begin
			applySeenOn_q <= 1'b0;
		end else if (modePin) begin
			applySeenOn_q <= 1'b0;
		end else if (applyPin && !applyPin_q) begin
			applySeenOn_q <= 1'b1;
		end else if (applyNow) begin
			applySeenOn_q <= 1'b0;
		end
	end
	assign applyNow = applySeenOn_q && !applyPin && applyPin_q && !modePin;

	// mode shown to the user side
	always_ff @(posedge clock) begin
		if (srst) begin
			settingMode <= 1'b1;
		end else begin
			settingMode <= !modePin;
		end
	end

	// apb phases: first access cycle prepares, second completes
	assign accessPhase = psel && penable;
	assign commitEdge = accessPhase && pready;
	assign wordIdx = paddr[15:2];

	// read decode; unmapped and system areas read zero
	always_comb begin
		rdWord = 16'h0000;
		rdOnly = 1'b1;
		rdRestricted = 1'b0;
		rdMapped = 1'b1;
		case (wordIdx)
			tmb_pkg::IDX_ERROR_CODE: begin
				rdWord = errorCode_q;
			end
			tmb_pkg::IDX_CH3_SCALING_ENABLE: begin
				rdWord = enStage_q[0];
				rdOnly = 1'b0;
				rdRestricted = 1'b1;
			end
			tmb_pkg::IDX_CH3_SCALING_LOWER_LIMIT: begin
				rdWord = loStage_q[0];
				rdOnly = 1'b0;
				rdRestricted = 1'b1;
			end
			tmb_pkg::IDX_CH3_SCALING_UPPER_LIMIT: begin
				rdWord = upStage_q[0];
				rdOnly = 1'b0;
				rdRestricted = 1'b1;
			end
			tmb_pkg::IDX_CH3_SCALED_VALUE: begin
				rdWord = scaled_q[0];
			end
			tmb_pkg::IDX_CH4_SCALING_ENABLE: begin
				rdWord = enStage_q[1];
				rdOnly = 1'b0;
				rdRestricted = 1'b1;
			end
			tmb_pkg::IDX_CH4_SCALING_LOWER_LIMIT: begin
				rdWord = loStage_q[1];
				rdOnly = 1'b0;
				rdRestricted = 1'b1;
			end
			tmb_pkg::IDX_CH4_SCALING_UPPER_LIMIT: begin
				rdWord = upStage_q[1];
				rdOnly = 1'b0;
				rdRestricted = 1'b1;
			end
			tmb_pkg::IDX_CH4_SCALED_VALUE: begin
				rdWord = scaled_q[1];
			end
			tmb_pkg::IDX_SENSOR_COMPENSATION_SELECT: begin
				rdWord = sensStage_q;
				rdOnly = 1'b0;
				rdRestricted = 1'b1;
			end
			tmb_pkg::IDX_CONVERSION_DONE_FLAGS: begin
				rdWord = doneFlags_q;
			end
			tmb_pkg::IDX_EXTENSION_BITS_MONITOR: begin
				rdWord = extBits_q;
			end
			tmb_pkg::IDX_SAMPLE_PERIOD_MONITOR: begin
				rdWord = samplePeriod_q;
			end
			default: begin
				rdWord = 16'h0000;
				rdMapped = 1'b0; // holes swallow writes silently
			end
		endcase
	end

	// a write lands only on a writable area, whole low word, in setting mode
	assign wrLegal = !rdOnly && (pstrb[1:0] == 2'h3) && !(rdRestricted && modePin);
	assign wrCommit = commitEdge && pwrite && wrLegal;

	// apb answer, registered; pready one cycle after access starts
	always_ff @(posedge clock) begin
		if (srst) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (accessPhase && !pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h00000000 : {16'h0000, rdWord};
			// refusal depends on the area class and the low strobes, never on the word's current value
			pslverr <= pwrite && rdMapped && (rdOnly || pstrb[1:0] != 2'h3);
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// host-written copies of the restricted settings
	always_ff @(posedge clock) begin
		if (srst) begin
			enStage_q <= '0;
			loStage_q <= '0;
			upStage_q <= '0;
			sensStage_q <= tmb_pkg::RST_WORD;
		end else if (wrCommit) begin
			case (wordIdx)
				tmb_pkg::IDX_CH3_SCALING_ENABLE: enStage_q[0] <= pwdata[15:0];
				tmb_pkg::IDX_CH3_SCALING_LOWER_LIMIT: loStage_q[0] <= pwdata[15:0];
				tmb_pkg::IDX_CH3_SCALING_UPPER_LIMIT: upStage_q[0] <= pwdata[15:0];
				tmb_pkg::IDX_CH4_SCALING_ENABLE: enStage_q[1] <= pwdata[15:0];
				tmb_pkg::IDX_CH4_SCALING_LOWER_LIMIT: loStage_q[1] <= pwdata[15:0];
				tmb_pkg::IDX_CH4_SCALING_UPPER_LIMIT: upStage_q[1] <= pwdata[15:0];
				tmb_pkg::IDX_SENSOR_COMPENSATION_SELECT: sensStage_q <= pwdata[15:0];
				default: begin
				end
			endcase
		end else if (rangeChanged && autoChangeEnable) begin
			// only areas flagged for automatic setting reload
			if (tmb_pkg::AUTO_SCALING) begin
				enStage_q <= '0;
				loStage_q <= '0;
				upStage_q <= '0;
			end
			if (tmb_pkg::AUTO_SENSOR) begin
				sensStage_q <= tmb_pkg::RST_WORD;
			end
		end
	end

	// applied settings; staged values only steer the logic after the pulse
	always_ff @(posedge clock) begin
		if (srst) begin
			enAct_q <= '0;
			loAct_q <= '0;
			upAct_q <= '0;
			sensAct_q <= tmb_pkg::RST_WORD;
		end else if (applyNow) begin
			enAct_q <= enStage_q;
			loAct_q <= loStage_q;
			upAct_q <= upStage_q;
			sensAct_q <= sensStage_q;
		end
	end

	// error code; sticky until reset
	always_ff @(posedge clock) begin
		if (srst) begin
			errorCode_q <= tmb_pkg::ERR_NONE;
		end else if (commitEdge && pwrite && rdRestricted && modePin) begin
			errorCode_q <= tmb_pkg::ERR_WRITE_DATA;
		end
	end

	// scaled value: lower + (upper - lower) * pv / 65536; zero when disabled
	always_ff @(posedge clock) begin
		logic signed [16:0] span;
		logic signed [33:0] prod;
		if (srst) begin
			scaled_q <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				span = $signed({upAct_q[c][15], upAct_q[c]}) - $signed({loAct_q[c][15], loAct_q[c]});
				prod = span * $signed({1'b0, (c == 0) ? process_value_ch3 : process_value_ch4});
				if (enAct_q[c] != 16'h0000) begin
					scaled_q[c] <= 16'(loAct_q[c] + prod[31:16]);
				end else begin
					scaled_q[c] <= 16'h0000;
				end
			end
		end
	end

	// monitor words sampled from converter logic on this clock
	always_ff @(posedge clock) begin
		if (srst) begin
			doneFlags_q <= tmb_pkg::RST_WORD;
			extBits_q <= tmb_pkg::RST_WORD;
			samplePeriod_q <= tmb_pkg::RST_WORD;
		end else begin
			doneFlags_q <= conversionDoneIn;
			extBits_q <= extensionBitsIn;
			samplePeriod_q <= samplePeriodIn;
		end
	end

	// next index to load: the data register must carry the word of the index it shows
	assign bkSel = nvWrValid ? nvWrIndex + 3'h1 : nvWrIndex;

	// backup word selected by index; monitors are never streamed
	always_comb begin
		bkWord = 16'h0000;
		case (bkSel)
			3'h0: bkWord = enAct_q[0];
			3'h1: bkWord = loAct_q[0];
			3'h2: bkWord = upAct_q[0];
			3'h3: bkWord = enAct_q[1];
			3'h4: bkWord = loAct_q[1];
			3'h5: bkWord = upAct_q[1];
			3'h6: bkWord = sensAct_q;
			default: bkWord = 16'h0000;
		endcase
	end

	// backup stream: seven words, one per cycle, on a rising request
	always_ff @(posedge clock) begin
		if (srst) begin
			bkState_q <= tmb_pkg::BK_IDLE;
			nvWrIndex <= tmb_pkg::BACKUP_FIRST;
			nvWrValid <= 1'b0;
			nvWrData <= 16'h0000;
			backupBusy <= 1'b0;
		end else begin
			case (bkState_q)
				tmb_pkg::BK_IDLE: begin
					nvWrValid <= 1'b0;
					nvWrIndex <= tmb_pkg::BACKUP_FIRST;
					if (backupPin && !backupPin_q) begin
						bkState_q <= tmb_pkg::BK_COPY;
						backupBusy <= 1'b1;
					end
				end
				tmb_pkg::BK_COPY: begin
					nvWrValid <= 1'b1;
					nvWrData <= bkWord;
					if (nvWrValid) begin
						nvWrIndex <= nvWrIndex + 3'h1;
					end
					if (nvWrValid && nvWrIndex == tmb_pkg::BACKUP_LAST - 3'h1) begin
						bkState_q <= tmb_pkg::BK_IDLE;
						backupBusy <= 1'b0;
					end
				end
				default: begin
					bkState_q <= tmb_pkg::BK_IDLE;
				end
			endcase
		end
	end

	ro_write_ignored_a: assert property (@(posedge clock) disable iff (srst)
		commitEdge && pwrite && wordIdx == tmb_pkg::IDX_CH3_SCALED_VALUE |=> $stable(enStage_q))
		else $error("read-only write changed settings");
	op_mode_error_a: assert property (@(posedge clock) disable iff (srst)
		commitEdge && pwrite && rdRestricted && modePin |=> errorCode_q == tmb_pkg::ERR_WRITE_DATA)
		else $error("operation-mode write did not raise error");
	op_mode_blocked_a: assert property (@(posedge clock) disable iff (srst)
		commitEdge && pwrite && rdRestricted && modePin |=> $stable(enStage_q) && $stable(sensStage_q))
		else $error("operation-mode write was stored");
	apply_copies_a: assert property (@(posedge clock) disable iff (srst)
		applyNow |=> enAct_q == $past(enStage_q) && sensAct_q == $past(sensStage_q))
		else $error("apply pulse did not copy settings");
	no_apply_hold_a: assert property (@(posedge clock) disable iff (srst)
		!applyNow |=> $stable(loAct_q) && $stable(upAct_q))
		else $error("applied limits changed without pulse");
	backup_starts_a: assert property (@(posedge clock) disable iff (srst)
		bkState_q == tmb_pkg::BK_IDLE && backupPin && !backupPin_q |=> ##[1:2] nvWrValid && nvWrIndex == 3'h0)
		else $error("backup did not start");
	system_read_zero_a: assert property (@(posedge clock) disable iff (srst)
		accessPhase && !pready && !pwrite && wordIdx == 14'h0315 |=> prdata == 32'h00000000)
		else $error("system area read not zero");
	upper_half_zero_a: assert property (@(posedge clock) disable iff (srst)
		pready |-> prdata[31:16] == 16'h0000)
		else $error("upper half of read data not zero");
	answer_timing_a: assert property (@(posedge clock) disable iff (srst)
		accessPhase && !pready |=> pready ##1 !pready)
		else $error("apb answer not one cycle");
	disabled_zero_a: assert property (@(posedge clock) disable iff (srst)
		enAct_q[0] == 16'h0000 |=> scaled_q[0] == 16'h0000)
		else $error("disabled channel scaled value nonzero");
	monitor_follow_a: assert property (@(posedge clock) disable iff (srst)
		1'b1 |=> doneFlags_q == $past(conversionDoneIn))
		else $error("done flags not following converter");
endmodule

// *** sim/tmb_host_model.sv ***
`timescale 1ns/10ps
// host side: drives mode, apply and backup pins, keeps the backed-up words
module tmb_host_model (
	input wire logic clock,
	input wire logic srst,
	output logic backup_request_output,
	output logic apply_settings_output,
	output logic mode_select_output,
	input wire logic nvWrValid,
	input wire logic [2:0] nvWrIndex,
	input wire logic [15:0] nvWrData
);
	logic [15:0] nvMem [0:7]; // non-volatile copy
	int nvCnt = 0; // words stored since the last request
	logic reqPrev = 1'b0; // request level at the last edge
	// pins start off, so the module wakes in setting mode
	initial begin
		backup_request_output = 1'b0;
		apply_settings_output = 1'b0;
		mode_select_output = 1'b0;
	end
	// store every streamed word; reset does not erase it, like real storage
	// the count restarts on a rising request, so only this process drives it
	always @(posedge clock) begin
		reqPrev <= backup_request_output;
		if (nvWrValid === 1'b1) begin
			nvMem[nvWrIndex] <= nvWrData;
			nvCnt <= nvCnt + 1;
		end else if (backup_request_output && !reqPrev) begin
			nvCnt <= 0;
		end
	end
	// off-on-off; each level held long enough to cross the synchroniser
	task automatic pulse_apply();
		@(posedge clock);
		apply_settings_output <= 1'b1;
		repeat (6) @(posedge clock);
		apply_settings_output <= 1'b0;
		repeat (12) @(posedge clock);
	endtask
	// off to on starts the copy; held on until the stream is surely over
	task automatic do_backup();
		@(posedge clock);
		backup_request_output <= 1'b1;
		repeat (24) @(posedge clock);
		backup_request_output <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	// low selects setting mode, high operation mode
	task automatic set_mode(input logic m);
		@(posedge clock);
		mode_select_output <= m;
		repeat (8) @(posedge clock);
	endtask
endmodule

// *** sim/temp_module_buffer_memory_map_test.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin $display("BAD t=%0t got=%h exp=%h", $time, g, e); error_cnt++; end end
module temp_module_buffer_memory_map_test;
	logic clock, srst, psel, penable, pwrite, pready, pslverr, err;
	logic [15:0] paddr, rd;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic backup_request_output, apply_settings_output, mode_select_output;
	logic rangeChanged, autoChangeEnable, nvWrValid, backupBusy, settingMode;
	logic [15:0] process_value_ch3, process_value_ch4, conversionDoneIn, extensionBitsIn, samplePeriodIn;
	logic [15:0] nvWrData;
	logic [2:0] nvWrIndex;
	int error_cnt = 0;
	int tests_run = 0;
	logic [15:0] mdl [14'h0000:14'h0315]; // expected contents of every word
	// read/write words, in backup stream order
	logic [13:0] rwIdx [7] = '{tmb_pkg::IDX_CH3_SCALING_ENABLE, tmb_pkg::IDX_CH3_SCALING_LOWER_LIMIT,
		tmb_pkg::IDX_CH3_SCALING_UPPER_LIMIT, tmb_pkg::IDX_CH4_SCALING_ENABLE, tmb_pkg::IDX_CH4_SCALING_LOWER_LIMIT,
		tmb_pkg::IDX_CH4_SCALING_UPPER_LIMIT, tmb_pkg::IDX_SENSOR_COMPENSATION_SELECT};
	// read-only words
	logic [13:0] roIdx [6] = '{tmb_pkg::IDX_ERROR_CODE, tmb_pkg::IDX_CH3_SCALED_VALUE, tmb_pkg::IDX_CH4_SCALED_VALUE,
		tmb_pkg::IDX_CONVERSION_DONE_FLAGS, tmb_pkg::IDX_EXTENSION_BITS_MONITOR, tmb_pkg::IDX_SAMPLE_PERIOD_MONITOR};
	logic [13:0] sysIdx [3] = '{14'h02e9, 14'h0309, 14'h0315}; // reserved holes

	tmb_buffer_map u_dut (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .backup_request_output, .apply_settings_output, .mode_select_output, .rangeChanged,
		.autoChangeEnable, .process_value_ch3, .process_value_ch4, .conversionDoneIn, .extensionBitsIn,
		.samplePeriodIn, .nvWrValid, .nvWrIndex, .nvWrData, .backupBusy, .settingMode);
	tmb_host_model u_host (.clock, .srst, .backup_request_output, .apply_settings_output, .mode_select_output,
		.nvWrValid, .nvWrIndex, .nvWrData);

	// 25 MHz
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// one apb transfer; entered just after an edge, idle cycle before setup
	task automatic apb(input logic wr, input logic [13:0] idx, input logic [15:0] wd, input logic [3:0] st);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, wd};
		pstrb <= st;
		@(posedge clock);
		penable <= 1'b1;
		// wait for the answer, bounded
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata[15:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			error_cnt++;
			close_out();
		end
	endtask

	// write and check the response flag
	task automatic wchk(input logic [13:0] idx, input logic [15:0] wd, input logic [3:0] st, input logic e);
		apb(1'b1, idx, wd, st);
		`CHK(err, e)
	endtask

	// read and compare against the model
	task automatic rchk(input logic [13:0] idx);
		apb(1'b0, idx, 16'h0000, 4'hf);
		`CHK(rd, mdl[idx])
		`CHK(err, 1'b0)
	endtask

	// lower + span * pv / 65536 when enabled, else zero
	function automatic logic [15:0] scaled(input logic [15:0] en, lo, up, pv);
		longint d;
		d = longint'($signed(up)) - longint'($signed(lo));
		return (en == 16'h0000) ? 16'h0000 : 16'(longint'($signed(lo)) + ((d * longint'(pv)) >>> 16));
	endfunction

	// main sequence
	initial begin
		{psel, penable, pwrite, rangeChanged, autoChangeEnable} = '0;
		{paddr, pwdata, pstrb} = '0;
		{process_value_ch3, process_value_ch4, conversionDoneIn, extensionBitsIn, samplePeriodIn} = '0;
		srst = 1'b1;
		for (int i = 0; i <= 14'h0315; i++) mdl[i] = 16'h0000;
		void'($urandom(32'h2e4388e6));
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		repeat (6) @(posedge clock);
		// defaults after reset
		foreach (rwIdx[i]) rchk(rwIdx[i]);
		foreach (roIdx[i]) rchk(roIdx[i]);
		`CHK(settingMode, 1'b1)
		// monitor words follow their inputs
		conversionDoneIn <= 16'($urandom());
		extensionBitsIn <= 16'($urandom());
		samplePeriodIn <= 16'($urandom());
		@(posedge clock);
		mdl[tmb_pkg::IDX_CONVERSION_DONE_FLAGS] = conversionDoneIn;
		mdl[tmb_pkg::IDX_EXTENSION_BITS_MONITOR] = extensionBitsIn;
		mdl[tmb_pkg::IDX_SAMPLE_PERIOD_MONITOR] = samplePeriodIn;
		// read-only words refuse writes and keep their value
		foreach (roIdx[i]) begin
			wchk(roIdx[i], 16'($urandom()), 4'hf, 1'b1);
			rchk(roIdx[i]);
		end
		// reserved holes swallow writes and read zero
		foreach (sysIdx[i]) begin
			wchk(sysIdx[i], 16'hffff, 4'hf, 1'b0);
			rchk(sysIdx[i]);
		end
		// a single-byte write is refused
		wchk(rwIdx[0], 16'h1234, 4'h1, 1'b1);
		rchk(rwIdx[0]);
		// fill every setting; ch3 enabled with ordered limits, ch4 disabled
		foreach (rwIdx[i]) mdl[rwIdx[i]] = 16'($urandom());
		mdl[rwIdx[0]] = mdl[rwIdx[0]] | 16'h0001;
		mdl[rwIdx[3]] = 16'h0000;
		mdl[rwIdx[1]] = 16'($urandom_range(0, 32'h3fff)) - 16'h2000;
		mdl[rwIdx[2]] = mdl[rwIdx[1]] + 16'($urandom_range(0, 32'h3fff));
		foreach (rwIdx[i]) wchk(rwIdx[i], mdl[rwIdx[i]], 4'hf, 1'b0);
		process_value_ch3 <= 16'($urandom());
		process_value_ch4 <= 16'($urandom());
		foreach (rwIdx[i]) rchk(rwIdx[i]);
		// nothing takes effect before the apply pulse
		rchk(tmb_pkg::IDX_CH3_SCALED_VALUE);
		u_host.pulse_apply();
		mdl[tmb_pkg::IDX_CH3_SCALED_VALUE] = scaled(mdl[rwIdx[0]], mdl[rwIdx[1]], mdl[rwIdx[2]], process_value_ch3);
		rchk(tmb_pkg::IDX_CH3_SCALED_VALUE);
		rchk(tmb_pkg::IDX_CH4_SCALED_VALUE);
		// no area here is flagged for automatic setting
		autoChangeEnable <= 1'b1;
		rangeChanged <= 1'b1;
		@(posedge clock);
		rangeChanged <= 1'b0;
		foreach (rwIdx[i]) rchk(rwIdx[i]);
		// backup streams the applied settings in order
		u_host.do_backup();
		`CHK(u_host.nvCnt, 7)
		`CHK(backupBusy, 1'b0)
		foreach (rwIdx[i]) `CHK(u_host.nvMem[i], mdl[rwIdx[i]])
		// operation mode: restricted write ignored, error code raised
		u_host.set_mode(1'b1);
		`CHK(settingMode, 1'b0)
		wchk(rwIdx[0], ~mdl[rwIdx[0]], 4'hf, 1'b0);
		rchk(rwIdx[0]);
		mdl[tmb_pkg::IDX_ERROR_CODE] = tmb_pkg::ERR_WRITE_DATA;
		rchk(tmb_pkg::IDX_ERROR_CODE);
		close_out();
	end
endmodule
